// file: verilog/fad_regs.svh
// Offsets, field positions, reset values and timing counts of the unit
`ifndef FAD_REGS_SVH
`define FAD_REGS_SVH
`define FAD_OFF_SRC1    8'h00
`define FAD_OFF_SRC2    8'h04
`define FAD_OFF_ISSUE   8'h08
`define FAD_OFF_ADDRES  8'h0c
`define FAD_OFF_DIVRES  8'h10
`define FAD_OFF_STATUS  8'h14
`define FAD_OFF_INFO    8'h18
`define FAD_F_DBZ       7'h01
`define FAD_F_INX       7'h02
`define FAD_F_UNF       7'h04
`define FAD_F_OVF       7'h08
`define FAD_F_INV       7'h10
`define FAD_F_IFZ       7'h20
`define FAD_F_OFZ       7'h40
`define FAD_OPC_ADDFL   8'h70
`define FAD_OPC_DIV     8'h6c
`define FAD_SLOT_ADD_A  3'h1
`define FAD_SLOT_ADD_B  3'h4
`define FAD_SLOT_DIV    3'h2
`define FAD_ISS_SLOT    8
`define FAD_ISS_GEN     16
`define FAD_ISS_GRD     17
`define FAD_ST_RM       8
`define FAD_INFO_REF    2
`define FAD_ADD_LAT     3
`define FAD_DIV_LAT     17
`define FAD_DIV_REC     16
`define FAD_DIV_STEPS   4'he
`define FAD_BIAS        10'sd127
`define FAD_EMAX        10'sd254
`define FAD_QNAN        32'hffffffff
`define FAD_RST_WORD    32'h00000000
`endif

// file: verilog/fad_pkg.sv
// Types and shared float helpers of the add-flags and divide unit
`include "fad_regs.svh"
package fad_pkg;
  typedef struct packed {
    logic [31:0] val;
    logic [6:0]  flg;
  } fad_res_t;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    logic [1:0]  rm;
    logic        wen;
  } fad_op_t;
  typedef struct packed {
    logic den;
    logic nan;
    logic snan;
    logic inf;
    logic zer;
  } fad_cls_t;
  typedef enum logic [1:0] {
    fad_s_idle = 2'b01,
    fad_s_run  = 2'b10
  } fad_dst_t;
  function automatic fad_cls_t fad_class(input logic [31:0] x);
    fad_cls_t c;
    c.zer  = x[30:23] == 8'h00;
    c.den  = c.zer && x[22:0] != 23'h0;
    c.inf  = x[30:23] == 8'hff && x[22:0] == 23'h0;
    c.nan  = x[30:23] == 8'hff && x[22:0] != 23'h0;
    c.snan = c.nan && !x[22];
    return c;
  endfunction
  function automatic fad_res_t fad_round(input logic s, input logic signed [9:0] e,
      input logic [23:0] m, input logic g, input logic st, input logic [1:0] rm);
    logic              inc;
    logic [24:0]       mr;
    logic signed [9:0] er;
    fad_res_t          r;
    case (rm)
      2'h0: inc = g & (st | m[0]);
      2'h1: inc = ~s & (g | st);
      2'h2: inc = s & (g | st);
      default: inc = 1'b0;
    endcase
    mr = {1'b0, m} + {24'h0, inc};
    er = e + signed'({9'h0, mr[24]});
    r.flg = (g | st) ? `FAD_F_INX : 7'h00;
    r.val = {s, er[7:0], mr[24] ? mr[23:1] : mr[22:0]};
    if (e < 10'sd1) begin
      r.val = {s, 31'h0};
      r.flg = `FAD_F_OFZ | `FAD_F_UNF | `FAD_F_INX;
    end else if (er > `FAD_EMAX) begin
      r.val = {s, 8'hff, 23'h0};
      r.flg = `FAD_F_OVF | `FAD_F_INX;
    end
    return r;
  endfunction
endpackage

// file: verilog/fad_addfl.sv
// Exception flag vector that a single-precision add would raise
`timescale 1ns/1ps
`include "fad_regs.svh"
module fad_addfl (
  input  fad_pkg::fad_op_t op_i,
  output logic [6:0]       flg_o
);
  import fad_pkg::*;
  fad_cls_t          ca;
  fad_cls_t          cb;
  logic [31:0]       xb;
  logic [31:0]       xs;
  logic [7:0]        d;
  logic [53:0]       ext;
  logic [26:0]       sh;
  logic [23:0]       sb;
  logic [27:0]       sum;
  logic [26:0]       nrm;
  logic [4:0]        lz;
  logic              fnd;
  logic signed [9:0] eb;
  fad_res_t          rr;
  always_comb begin
    ca = fad_class(op_i.a);
    cb = fad_class(op_i.b);
    // Denormals count as zero in the magnitude order
    xb = ((cb.zer ? 31'h0 : op_i.b[30:0]) > (ca.zer ? 31'h0 : op_i.a[30:0])) ? op_i.b : op_i.a;
    xs = (xb == op_i.b && op_i.a != op_i.b) ? op_i.a : op_i.b;
    d = xb[30:23] - xs[30:23];
    sb = (xb[30:23] == 8'h00) ? 24'h0 : {1'b1, xb[22:0]};
    ext = {(xs[30:23] == 8'h00) ? 24'h0 : {1'b1, xs[22:0]}, 30'h0} >> ((d > 8'd28) ? 8'd28 : d);
    sh = ext[53:27] | {26'h0, |ext[26:0]};
    sum = (op_i.a[31] ^ op_i.b[31]) ? {1'b0, sb, 3'h0} - {1'b0, sh} : {1'b0, sb, 3'h0} + {1'b0, sh};
    lz = 5'h0;
    fnd = 1'b0;
    for (int i = 26; i >= 0; i--) begin
      if (!fnd && sum[i]) begin
        fnd = 1'b1;
      end else if (!fnd) begin
        lz = lz + 5'h1;
      end
    end
    nrm = sum[26:0] << lz;
    eb = signed'({2'h0, xb[30:23]});
    if (sum[27]) begin
      rr = fad_round(xb[31], eb + 10'sd1, sum[27:4], sum[3], |sum[2:0], op_i.rm);
    end else begin
      rr = fad_round(xb[31], eb - signed'({5'h0, lz}), nrm[26:3], nrm[2], |nrm[1:0], op_i.rm);
    end
    flg_o = (ca.den | cb.den) ? `FAD_F_IFZ : 7'h00;
    if (ca.nan | cb.nan) begin
      flg_o = flg_o | ((ca.snan | cb.snan) ? `FAD_F_INV : 7'h00);
    end else if (ca.inf & cb.inf & (op_i.a[31] ^ op_i.b[31])) begin
      flg_o = flg_o | `FAD_F_INV;
    end else if (!(ca.inf | cb.inf) && sum != 28'h0) begin
      flg_o = flg_o | rr.flg;
    end
  end
endmodule

// file: verilog/fad_div.sv
// Iterative single-precision divider, two quotient bits per clock
`timescale 1ns/1ps
`include "fad_regs.svh"
module fad_div (
  input  logic              clk,
  input  logic              rst_n,
  input  logic              start_i,
  input  fad_pkg::fad_op_t  op_i,
  output logic              done_o,
  output logic              wen_o,
  output fad_pkg::fad_res_t res_o
);
  import fad_pkg::*;
  fad_dst_t          st_r, st_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic [25:0]       rem_r, rem_nxt;
  logic [23:0]       dv_r, dv_nxt;
  logic [27:0]       q_r, q_nxt;
  logic signed [9:0] ex_r, ex_nxt;
  logic [1:0]        rm_r, rm_nxt;
  logic              sg_r, sg_nxt, wen_r, wen_nxt, sp_r, sp_nxt, done_r, done_nxt;
  fad_res_t          spv_r, spv_nxt, res_r, res_nxt, fin;
  fad_cls_t          ca;
  fad_cls_t          cb;
  assign done_o = done_r;
  assign wen_o  = wen_r;
  assign res_o  = res_r;
  always_comb begin
    st_nxt = st_r;
    {cnt_nxt, rem_nxt, dv_nxt, q_nxt, ex_nxt} = {cnt_r, rem_r, dv_r, q_r, ex_r};
    {rm_nxt, sg_nxt, wen_nxt, sp_nxt, spv_nxt, res_nxt} = {rm_r, sg_r, wen_r, sp_r, spv_r, res_r};
    done_nxt = 1'b0;
    fin = '0;
    ca = fad_class(op_i.a);
    cb = fad_class(op_i.b);
    case (st_r)
      fad_s_idle: if (start_i) begin
        st_nxt = fad_s_run;
        cnt_nxt = `FAD_DIV_STEPS;
        rem_nxt = ca.zer ? 26'h0 : {3'h1, op_i.a[22:0]};
        dv_nxt = {1'b1, op_i.b[22:0]};
        q_nxt = 28'h0;
        ex_nxt = signed'({2'h0, op_i.a[30:23]}) - signed'({2'h0, op_i.b[30:23]}) + `FAD_BIAS;
        sg_nxt = op_i.a[31] ^ op_i.b[31];
        rm_nxt = op_i.rm;
        wen_nxt = op_i.wen;
        spv_nxt.flg = (ca.den | cb.den) ? `FAD_F_IFZ : 7'h00;
        spv_nxt.val = `FAD_QNAN;
        sp_nxt = 1'b1;
        if (ca.nan | cb.nan) begin
          spv_nxt.flg = spv_nxt.flg | ((ca.snan | cb.snan) ? `FAD_F_INV : 7'h00);
        end else if ((ca.inf & cb.inf) | (ca.zer & cb.zer)) begin
          spv_nxt.flg = spv_nxt.flg | `FAD_F_INV;
        end else if (ca.inf | cb.zer) begin
          spv_nxt.val = {sg_nxt, 8'hff, 23'h0};
          spv_nxt.flg = spv_nxt.flg | ((cb.zer & ~ca.inf) ? `FAD_F_DBZ : 7'h00);
        end else if (cb.inf | ca.zer) begin
          spv_nxt.val = {sg_nxt, 31'h0};
        end else begin
          sp_nxt = 1'b0;
        end
      end
      fad_s_run: begin
        for (int k = 0; k < 2; k++) begin
          if (rem_nxt >= {2'h0, dv_r}) begin
            rem_nxt = rem_nxt - {2'h0, dv_r};
            q_nxt = {q_nxt[26:0], 1'b1};
          end else begin
            q_nxt = {q_nxt[26:0], 1'b0};
          end
          rem_nxt = {rem_nxt[24:0], 1'b0};
        end
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          st_nxt = fad_s_idle;
          done_nxt = 1'b1;
          if (q_nxt[27]) begin
            fin = fad_round(sg_r, ex_r, q_nxt[27:4], q_nxt[3], (|q_nxt[2:0]) | (|rem_nxt), rm_r);
          end else begin
            fin = fad_round(sg_r, ex_r - 10'sd1, q_nxt[26:3], q_nxt[2], (|q_nxt[1:0]) | (|rem_nxt),
                            rm_r);
          end
          fin.flg = fin.flg | spv_r.flg;
          res_nxt = sp_r ? spv_r : fin;
        end
      end
      default: st_nxt = fad_s_idle;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= fad_s_idle;
      {cnt_r, rem_r, dv_r, q_r, ex_r} <= {4'h0, 26'h0, 24'h0, 28'h0, 10'sd0};
      {rm_r, sg_r, wen_r, sp_r, done_r} <= 6'h00;
      spv_r <= '0;
      res_r <= '0;
    end else begin
      st_r <= st_nxt;
      {cnt_r, rem_r, dv_r, q_r, ex_r} <= {cnt_nxt, rem_nxt, dv_nxt, q_nxt, ex_nxt};
      {rm_r, sg_r, wen_r, sp_r, done_r} <= {rm_nxt, sg_nxt, wen_nxt, sp_nxt, done_nxt};
      spv_r <= spv_nxt;
      res_r <= res_nxt;
    end
  end
endmodule

// file: verilog/fad_top.sv
// Add-flags and divide datapath with its status word behind a Wishbone slave
// How it works
// - Add-flags: opcode 112, latency 3, slots 1/4
// - Add-flags returns exception bits, not sum
// - Returned vector uses status word bit layout
// - Add-flags never touches status word flags
// - Both round by status word rounding mode
// - Add-flags flushes denormal inputs, reports 0x20
// - Denormal sum reports output-flushed bit
// - Output-flushed 0x40, underflow 0x4, inexact 0x2
// - Overflow is 0x8, with inexact 0xa
// - Input-flushed 0x20, invalid 0x10
// - Divide-by-zero is 0x1
// - Guarded add-flags writes only when guard set
// - Divide: opcode 108, latency 17, recovery 16, slot 2
// - Divide writes rounded first over second
// - Divide flushes denormal inputs, sets input-flushed
// - Denormal quotient becomes zero, sets output-flushed
// - Divide exceptions set status word flags
// - Flags sticky; only status write clears
// - Flags update with divide destination write
// - Simultaneous status write and divide update OR divide flags into written flags
// - Guarded divide changes nothing when guard clear
// - Normal over zero gives infinity, divide-by-zero
// - Infinity over infinity gives all-ones NaN, invalid
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fad_regs.svh"
module fad_top (
  input  logic        clk_sys,
  input  logic        resetn,
  input  logic        wb_cyc_i,
  input  logic        wb_stb_i,
  input  logic        wb_we_i,
  input  logic [7:0]  wb_adr_i,
  input  logic [3:0]  wb_sel_i,
  input  logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o
);
  import fad_pkg::*;

  localparam int ADD_DEPTH = `FAD_ADD_LAT - 1;
  localparam int DIV_TOP   = `FAD_DIV_LAT - 1;

  logic [1:0]           rs_r;
  logic                 rst_n;
  logic                 ack_r;
  logic                 ack_nxt;
  logic [31:0]          rd_r;
  logic [31:0]          rd_nxt;
  logic [31:0]          src1_r;
  logic [31:0]          src1_nxt;
  logic [31:0]          src2_r;
  logic [31:0]          src2_nxt;
  logic [6:0]           flg_r;
  logic [6:0]           flg_nxt;
  logic [1:0]           rm_r;
  logic [1:0]           rm_nxt;
  logic [31:0]          addres_r;
  logic [31:0]          addres_nxt;
  logic [31:0]          divres_r;
  logic [31:0]          divres_nxt;
  logic                 ref_r;
  logic                 ref_nxt;
  fad_op_t              aop_r;
  fad_op_t              aop_nxt;
  logic                 av_r;
  logic                 av_nxt;
  logic [6:0]           pf_r [ADD_DEPTH];
  logic [6:0]           pf_nxt [ADD_DEPTH];
  logic [ADD_DEPTH-1:0] pv_r;
  logic [ADD_DEPTH-1:0] pv_nxt;
  logic [ADD_DEPTH-1:0] pw_r;
  logic [ADD_DEPTH-1:0] pw_nxt;
  logic [DIV_TOP:0]     dsr_r;
  logic [DIV_TOP:0]     dsr_nxt;
  logic [3:0]           rec_r;
  logic [3:0]           rec_nxt;
  fad_res_t             pend_r;
  fad_res_t             pend_nxt;
  logic                 pendw_r;
  logic                 pendw_nxt;
  logic                 wr;
  logic                 iss;
  logic                 st_wr;
  logic [7:0]           opc;
  logic [2:0]           slot;
  logic                 gok;
  logic                 add_go;
  logic                 div_go;
  logic                 add_wr;
  logic                 div_wr;
  logic                 upd;
  fad_op_t              dop;
  logic [6:0]           add_flg;
  logic                 div_done;
  logic                 div_wen;
  fad_res_t             div_res;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] fad_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    return r;
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rs_r <= 2'h0;
    end else begin
      rs_r <= {rs_r[0], 1'b1};
    end
  end
  assign rst_n = rs_r[1];

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;

  // Bus decode and issue decode
  assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign iss    = wr && wb_adr_i == `FAD_OFF_ISSUE;
  assign st_wr  = wr && wb_adr_i == `FAD_OFF_STATUS;
  assign opc    = wb_dat_i[7:0];
  assign slot   = wb_dat_i[`FAD_ISS_SLOT +: 3];
  assign gok    = ~wb_dat_i[`FAD_ISS_GEN] | wb_dat_i[`FAD_ISS_GRD];
  assign add_go = iss && opc == `FAD_OPC_ADDFL &&
                  (slot == `FAD_SLOT_ADD_A || slot == `FAD_SLOT_ADD_B);
  assign div_go = iss && opc == `FAD_OPC_DIV && slot == `FAD_SLOT_DIV && rec_r == 4'h0;
  assign dop    = '{a: src1_r, b: src2_r, rm: rm_r, wen: gok};
  assign add_wr = pv_r[ADD_DEPTH-1] & pw_r[ADD_DEPTH-1];
  assign div_wr = dsr_r[DIV_TOP] & pendw_r;
  assign upd    = div_wr | st_wr;

  fad_addfl u_addfl (
    .op_i  (aop_r),
    .flg_o (add_flg)
  );

  fad_div u_div (
    .clk     (clk_sys),
    .rst_n   (rst_n),
    .start_i (div_go),
    .op_i    (dop),
    .done_o  (div_done),
    .wen_o   (div_wen),
    .res_o   (div_res)
  );

  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    rd_nxt = rd_r;
    if (ack_nxt && !wb_we_i) begin
      case (wb_adr_i)
        `FAD_OFF_SRC1:   rd_nxt = src1_r;
        `FAD_OFF_SRC2:   rd_nxt = src2_r;
        `FAD_OFF_ADDRES: rd_nxt = addres_r;
        `FAD_OFF_DIVRES: rd_nxt = divres_r;
        `FAD_OFF_STATUS: rd_nxt = {22'h0, rm_r, 1'b0, flg_r};
        `FAD_OFF_INFO:   rd_nxt = {29'h0, ref_r, |dsr_r | (rec_r != 4'h0), av_r | (|pv_r)};
        default:         rd_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rd_r <= `FAD_RST_WORD;
    end else begin
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
    end
  end

  always_comb begin
    src1_nxt = src1_r;
    src2_nxt = src2_r;
    if (wr && wb_adr_i == `FAD_OFF_SRC1) begin
      src1_nxt = fad_merge(src1_r, wb_dat_i, wb_sel_i);
    end
    if (wr && wb_adr_i == `FAD_OFF_SRC2) begin
      src2_nxt = fad_merge(src2_r, wb_dat_i, wb_sel_i);
    end
    ref_nxt = ref_r;
    if (wr && wb_adr_i == `FAD_OFF_INFO && wb_dat_i[`FAD_INFO_REF]) begin
      ref_nxt = 1'b0;
    end
    if (iss && !add_go && !div_go) begin
      ref_nxt = 1'b1;
    end
    aop_nxt = add_go ? dop : aop_r;
    av_nxt = add_go;
    pv_nxt[0] = av_r;
    pw_nxt[0] = aop_r.wen;
    pf_nxt[0] = add_flg;
    for (int i = 1; i < ADD_DEPTH; i++) begin
      pv_nxt[i] = pv_r[i-1];
      pw_nxt[i] = pw_r[i-1];
      pf_nxt[i] = pf_r[i-1];
    end
    addres_nxt = add_wr ? {25'h0, pf_r[ADD_DEPTH-1]} : addres_r;
    dsr_nxt = {dsr_r[DIV_TOP-1:0], div_go};
    if (div_go) begin
      rec_nxt = 4'(`FAD_DIV_REC - 1);
    end else begin
      rec_nxt = (rec_r != 4'h0) ? rec_r - 4'h1 : 4'h0;
    end
    pend_nxt = div_done ? div_res : pend_r;
    pendw_nxt = div_done ? div_wen : pendw_r;
    divres_nxt = div_wr ? pend_r.val : divres_r;
  end

  always_comb begin
    flg_nxt = flg_r;
    rm_nxt = rm_r;
    if (st_wr && wb_sel_i[0]) begin
      flg_nxt = wb_dat_i[6:0];
    end
    if (st_wr && wb_sel_i[1]) begin
      rm_nxt = wb_dat_i[`FAD_ST_RM +: 2];
    end
    if (div_wr) begin
      flg_nxt = flg_nxt | pend_r.flg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src1_r <= `FAD_RST_WORD;
      src2_r <= `FAD_RST_WORD;
      flg_r <= 7'h00;
      rm_r <= 2'h0;
      addres_r <= `FAD_RST_WORD;
      divres_r <= `FAD_RST_WORD;
      ref_r <= 1'b0;
      aop_r <= '0;
      av_r <= 1'b0;
      pv_r <= '0;
      pw_r <= '0;
      for (int i = 0; i < ADD_DEPTH; i++) begin
        pf_r[i] <= 7'h00;
      end
      dsr_r <= '0;
      rec_r <= 4'h0;
      pend_r <= '0;
      pendw_r <= 1'b0;
    end else begin
      src1_r <= src1_nxt;
      src2_r <= src2_nxt;
      flg_r <= flg_nxt;
      rm_r <= rm_nxt;
      addres_r <= addres_nxt;
      divres_r <= divres_nxt;
      ref_r <= ref_nxt;
      aop_r <= aop_nxt;
      av_r <= av_nxt;
      pv_r <= pv_nxt;
      pw_r <= pw_nxt;
      pf_r <= pf_nxt;
      dsr_r <= dsr_nxt;
      rec_r <= rec_nxt;
      pend_r <= pend_nxt;
      pendw_r <= pendw_nxt;
    end
  end

  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_add_iss;
    add_go && gok;
  endsequence
  sequence s_add_skip;
    add_go && !gok;
  endsequence

  property p_add_lat;
    s_add_iss |-> ##3 add_wr ##1 addres_r == {25'h0, $past(pf_r[ADD_DEPTH-1])};
  endproperty
  a_add_lat: assert property (p_add_lat) else $error("add flags not written after 3 cycles");

  property p_add_grd;
    s_add_skip |-> ##3 !add_wr ##1 $stable(addres_r);
  endproperty
  a_add_grd: assert property (p_add_grd) else $error("guarded add flags wrote");

  property p_add_nostat;
    add_wr && !div_wr && !st_wr |=> flg_r == $past(flg_r);
  endproperty
  a_add_nostat: assert property (p_add_nostat) else $error("add flags changed status");

  property p_div_lat;
    div_go && gok |-> ##17 div_wr;
  endproperty
  a_div_lat: assert property (p_div_lat) else $error("divide result not at 17 cycles");

  property p_div_rec;
    div_go |-> ##1 (rec_r != 4'h0)[*8] ##8 rec_r == 4'h0;
  endproperty
  a_div_rec: assert property (p_div_rec) else $error("divide recovery not 16 cycles");

  property p_sticky;
    !st_wr |=> (flg_r & $past(flg_r)) == $past(flg_r);
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag cleared");

  property p_flag_sync;
    (flg_r & ~$past(flg_r)) != 7'h00 |-> $past(upd);
  endproperty
  a_flag_sync: assert property (p_flag_sync) else $error("flag set without commit");

  property p_flag_or;
    div_wr && !st_wr |=> flg_r == ($past(flg_r) | $past(pend_r.flg));
  endproperty
  a_flag_or: assert property (p_flag_or) else $error("flags not ORed");

  property p_div_grd;
    dsr_r[DIV_TOP] && !pendw_r && !st_wr |=> $stable(divres_r) && flg_r == $past(flg_r);
  endproperty
  a_div_grd: assert property (p_div_grd) else $error("guarded divide changed state");

  property p_div_ofz;
    div_wr && (pend_r.flg & `FAD_F_OFZ) != 7'h00 |=> divres_r[30:0] == 31'h0;
  endproperty
  a_div_ofz: assert property (p_div_ofz) else $error("flushed quotient not zero");

  property p_div_dbz;
    div_wr && (pend_r.flg & `FAD_F_DBZ) != 7'h00 |=> divres_r[30:0] == 31'h7f800000;
  endproperty
  a_div_dbz: assert property (p_div_dbz) else $error("zero divisor not infinity");

endmodule

// file: testbench/fad_wb_master.sv
// Wishbone master standing in for the issue and register-file side
`timescale 1ns/1ps
module fad_wb_master (
  input  logic        clk,
  output logic        cyc_o,
  output logic        stb_o,
  output logic        we_o,
  output logic [7:0]  adr_o,
  output logic [3:0]  sel_o,
  output logic [31:0] dat_o,
  input  logic [31:0] dat_i,
  input  logic        ack_i
);
  logic [31:0] rd_data;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
    rd_data = 32'h00000000;
  end
  // One classic cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    @(posedge clk);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do @(posedge clk); while (ack_i !== 1'b1);
    rd_data = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // Released data lines stop showing the last value
    dat_o <= ~d;
  endtask
endmodule

// file: testbench/fp_addflags_and_divide_unit_tb_top.sv
// Self-checking bench of the add-flags and divide unit
`timescale 1ns/1ps
`include "fad_regs.svh"
module fp_addflags_and_divide_unit_tb_top;
  logic        clk_sys;
  logic        resetn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [31:0] pre, a, b, iss, q, st, pst;
  int          num_errors;
  int          checked;
  localparam logic [95:0] add_v [5] = '{
    {32'h7f7fffff, 32'h3f800000, 32'h02}, {32'h7f7fffff, 32'h7f7fffff, 32'h0a},
    {32'h00a00000, 32'h80800000, 32'h46}, {32'h7f800000, 32'hff800000, 32'h10},
    {32'h40400000, 32'h00400000, 32'h20}};
  localparam logic [191:0] div_v [9] = '{
    {32'h0, 32'h40400000, 32'h00400000, 32'h26c, 32'h7f800000, 32'h021},
    {32'hffffffff, 32'hc0400000, 32'h3f800000, 32'h26c, 32'hc0400000, 32'h021},
    {32'h0, 32'h7f800000, 32'hff800000, 32'h26c, 32'hffffffff, 32'h010},
    {32'h2, 32'h40400000, 32'h00000000, 32'h26c, 32'h7f800000, 32'h003},
    {32'h0, 32'h00800000, 32'h40000000, 32'h26c, 32'h00000000, 32'h046},
    {32'h0, 32'h40400000, 32'h00000000, 32'h1026c, 32'h00000000, 32'h000},
    {32'hffffffff, 32'h00c00000, 32'h80800000, 32'h3026c, 32'hbfc00000, 32'h000},
    {32'h300, 32'h3f800000, 32'h40400000, 32'h26c, 32'h3eaaaaaa, 32'h302},
    {32'h0, 32'h3f800000, 32'h40400000, 32'h26c, 32'h3eaaaaab, 32'h002}};
  fad_top dut (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .wb_cyc_i (cyc),
    .wb_stb_i (stb),
    .wb_we_i  (we),
    .wb_adr_i (adr),
    .wb_sel_i (sel),
    .wb_dat_i (wdat),
    .wb_dat_o (rdat),
    .wb_ack_o (ack)
  );
  fad_wb_master bus (
    .clk   (clk_sys),
    .cyc_o (cyc),
    .stb_o (stb),
    .we_o  (we),
    .adr_o (adr),
    .sel_o (sel),
    .dat_o (wdat),
    .dat_i (rdat),
    .ack_i (ack)
  );
  always #20 clk_sys = ~clk_sys;
  task automatic summarize;
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    bus.xfer(1'b0, ad, 32'h0, 4'hf);
    checked++;
    if (bus.rd_data !== exp) begin
      num_errors++;
      $display("wrong value at %0t: addr %h read %h expected %h", $time, ad, bus.rd_data, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
    bus.xfer(1'b1, ad, d, s);
  endtask
  task automatic op(input logic [31:0] x, input logic [31:0] y, input logic [31:0] i,
      input int gap);
    wr(`FAD_OFF_SRC1, x, 4'hf);
    wr(`FAD_OFF_SRC2, y, 4'hf);
    wr(`FAD_OFF_ISSUE, i, 4'hf);
    repeat (gap) @(posedge clk_sys);
  endtask
  initial begin
    repeat (8000) @(posedge clk_sys);
    num_errors++;
    summarize;
  end
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    num_errors = 0;
    checked = 0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdchk(`FAD_OFF_STATUS, 32'h0);
    for (int i = 0; i < 5; i++) begin
      op(add_v[i][95:64], add_v[i][63:32], i[0] ? 32'h470 : 32'h170, 0);
      rdchk(`FAD_OFF_ADDRES, i == 0 ? 32'h0 : add_v[i-1][31:0]);
      repeat (2) @(posedge clk_sys);
      rdchk(`FAD_OFF_ADDRES, add_v[i][31:0]);
    end
    rdchk(`FAD_OFF_STATUS, 32'h0);
    op(32'h7f800000, 32'hff800000, 32'h10170, 4);
    rdchk(`FAD_OFF_ADDRES, 32'h20);
    op(32'h7f800000, 32'hff800000, 32'h30470, 4);
    rdchk(`FAD_OFF_ADDRES, 32'h10);
    for (int i = 0; i < 9; i++) begin
      {pre, a, b, iss, q, st} = div_v[i];
      pst = (pre === 32'hffffffff) ? div_v[i-1][31:0] : pre;
      if (pre !== 32'hffffffff) begin
        wr(`FAD_OFF_STATUS, pre, 4'hf);
      end
      op(a, b, iss, 12);
      rdchk(`FAD_OFF_DIVRES, i == 0 ? 32'h0 : div_v[i-1][63:32]);
      rdchk(`FAD_OFF_STATUS, pst);
      repeat (4) @(posedge clk_sys);
      rdchk(`FAD_OFF_DIVRES, q);
      rdchk(`FAD_OFF_STATUS, st);
    end
    op(32'h3f800000, 32'h3f800000, 32'h26c, 0);
    wr(`FAD_OFF_ISSUE, 32'h26c, 4'hf);
    rdchk(`FAD_OFF_INFO, 32'h6);
    repeat (20) @(posedge clk_sys);
    wr(`FAD_OFF_INFO, 32'h4, 4'hf);
    rdchk(`FAD_OFF_INFO, 32'h0);
    op(32'h40400000, 32'h3f800000, 32'h16c, 20);
    rdchk(`FAD_OFF_INFO, 32'h4);
    rdchk(`FAD_OFF_DIVRES, 32'h3f800000);
    summarize;
  end
endmodule
